// [pkg/swl_pkg.sv]
// Shared constants and types for the single-wire link, both ends
package swl_pkg;

	localparam int unsigned CLK_MHZ                = 40;

	// Standard speed times, in ns
	localparam int unsigned STD_RESET_LOW_NS       = 480000;
	localparam int unsigned STD_RESET_DETECT_NS    = 400000;
	localparam int unsigned STD_PRESENCE_WAIT_NS   = 30000;
	localparam int unsigned STD_PRESENCE_LOW_NS    = 120000;
	localparam int unsigned STD_SLOT_DURATION_NS   = 120000;
	localparam int unsigned STD_WRITE_ONE_LOW_NS   = 6000;
	localparam int unsigned STD_WRITE_ONE_MAX_NS   = 15000;
	localparam int unsigned STD_WRITE_ZERO_MIN_NS  = 60000;
	localparam int unsigned STD_READ_VALID_NS      = 15000;
	localparam int unsigned STD_PRESENCE_SAMPLE_NS = 70000;
	localparam int unsigned STD_PRESENCE_REST_NS   = 410000;
	// Overdrive speed times, in ns
	localparam int unsigned OD_RESET_LOW_NS        = 56000;
	localparam int unsigned OD_RESET_DETECT_NS     = 48000;
	localparam int unsigned OD_PRESENCE_WAIT_NS    = 3000;
	localparam int unsigned OD_PRESENCE_LOW_NS     = 12000;
	localparam int unsigned OD_SLOT_DURATION_NS    = 16000;
	localparam int unsigned OD_WRITE_ONE_LOW_NS    = 1000;
	localparam int unsigned OD_WRITE_ONE_MAX_NS    = 2000;
	localparam int unsigned OD_WRITE_ZERO_MIN_NS   = 6000;
	localparam int unsigned OD_READ_VALID_NS       = 2000;
	localparam int unsigned OD_PRESENCE_SAMPLE_NS  = 8000;
	localparam int unsigned OD_PRESENCE_REST_NS    = 40000;
	localparam int unsigned RECOVERY_GAP_NS        = 1000;
	localparam int unsigned READ_INIT_LOW_NS       = 1000;

	localparam int unsigned CNT_W                  = 16;
	typedef logic [CNT_W-1:0] swl_cnt_t;

	// Least times round up, latest times round down
	function automatic swl_cnt_t swl_up(input int unsigned ns);
		swl_up = swl_cnt_t'((ns * CLK_MHZ + 999) / 1000);
	endfunction : swl_up
	function automatic swl_cnt_t swl_dn(input int unsigned ns);
		swl_dn = swl_cnt_t'((ns * CLK_MHZ) / 1000);
	endfunction : swl_dn

	// Cycle counts, index 0 standard, 1 overdrive
	localparam swl_cnt_t RESET_LOW_CYC [2]   = '{swl_up(STD_RESET_LOW_NS),
		swl_up(OD_RESET_LOW_NS)};
	localparam swl_cnt_t RESET_DET_CYC [2]   = '{swl_up(STD_RESET_DETECT_NS),
		swl_up(OD_RESET_DETECT_NS)};
	localparam swl_cnt_t PRES_WAIT_CYC [2]   = '{swl_up(STD_PRESENCE_WAIT_NS),
		swl_up(OD_PRESENCE_WAIT_NS)};
	localparam swl_cnt_t PRES_LOW_CYC  [2]   = '{swl_up(STD_PRESENCE_LOW_NS),
		swl_up(OD_PRESENCE_LOW_NS)};
	localparam swl_cnt_t SLOT_CYC      [2]   = '{swl_up(STD_SLOT_DURATION_NS),
		swl_up(OD_SLOT_DURATION_NS)};
	localparam swl_cnt_t W1_LOW_CYC    [2]   = '{swl_up(STD_WRITE_ONE_LOW_NS),
		swl_up(OD_WRITE_ONE_LOW_NS)};
	localparam swl_cnt_t SAMPLE_CYC    [2]   = '{swl_up(STD_WRITE_ONE_MAX_NS) + 16'h0004,
		swl_up(OD_WRITE_ONE_MAX_NS) + 16'h0004};
	localparam swl_cnt_t RDV_CYC       [2]   = '{swl_dn(STD_READ_VALID_NS),
		swl_dn(OD_READ_VALID_NS)};
	localparam swl_cnt_t PRES_SMP_CYC  [2]   = '{swl_up(STD_PRESENCE_SAMPLE_NS),
		swl_up(OD_PRESENCE_SAMPLE_NS)};
	localparam swl_cnt_t PRES_REST_CYC [2]   = '{swl_up(STD_PRESENCE_REST_NS),
		swl_up(OD_PRESENCE_REST_NS)};
	localparam swl_cnt_t REC_CYC             = swl_up(RECOVERY_GAP_NS);
	localparam swl_cnt_t RD_INIT_CYC         = swl_up(READ_INIT_LOW_NS);

	// Function codes
	localparam logic [7:0] CMD_SET_OVERDRIVE = 8'h8b;
	localparam logic [7:0] CMD_CLR_OVERDRIVE = 8'h8d;
	localparam logic [7:0] CMD_SOFT_RESET    = 8'hc4;
	localparam logic [7:0] CMD_SKIP_ADDRESS  = 8'hcc;
	localparam logic       SPEED_RESET       = 1'b0;

	typedef enum logic [1:0] {SWL_OP_RESET, SWL_OP_WRITE, SWL_OP_READ} swl_op_t;

endpackage : swl_pkg

// [pkg/swl_if.sv]
// Open-drain single line shared by bus master and device
`timescale 1ns/100ps
interface swl_if;
	logic dq;
	logic master_oe;
	logic device_oe;

	// Wired-AND with pull-up: any enabled driver pulls low
	assign dq = ~(master_oe | device_oe);

	modport master (input dq, output master_oe);
	modport device (input dq, output device_oe);
endinterface : swl_if

// [core/swl_device.sv]
// Device end: reset detect, presence, bit slots, byte shift and speed commands
// How it works
// - 8B overdrive, 8D standard, C4 soft reset
// - Standard speed after i_rst_b, clear-overdrive and soft reset; a line reset keeps the speed
// - Payload lengths per command, handled by user side
// - Master starts all slots except presence
// - Reset pulse answered with presence pulse
// - Master holds reset low, then releases
// - Rising edge, wait, then presence low
// - Falling edge on idle line starts slot
// - Master keeps full slot plus recovery
// - Sample between write-one max, write-zero min
// - Write one released before read-valid time
// - Write zero held low whole slot
// - Read slot starts with short low pulse
// - Master samples at read-valid time
// - Zero held through sample, released before end
// - Function codes only after address command; any first byte after reset counts as the address command
`timescale 1ns/100ps
module swl_device
	import swl_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	// Line
	swl_if.device           bus,
	// Received bytes
	output logic [7:0]      o_rx_data,
	output logic            o_rx_valid,
	output logic            o_rx_is_cmd,
	// Bytes to send
	input  wire logic [7:0] i_tx_data,
	input  wire logic       i_tx_load,
	output logic            o_tx_empty,
	// Status
	output logic            o_overdrive,
	output logic            o_line_reset,
	output logic            o_soft_reset
);
	import swl_pkg::*;

	typedef enum logic [2:0] {
		SWLD_IDLE, SWLD_LOW, SWLD_PWAIT, SWLD_PLOW, SWLD_SLOT, SWLD_WAITHI
	} swld_state_t;

	////////////////////////////////////////////////////////////////////////
	swld_state_t  st_ff, nxt_st;
	swl_cnt_t     cnt_ff, nxt_cnt;
	logic         dq_ff, nxt_dq;
	logic         od_ff, nxt_od;
	logic         oe_ff, nxt_oe;
	logic         bit_ff, nxt_bit;
	logic [7:0]   sh_ff, nxt_sh;
	logic [2:0]   nb_ff, nxt_nb;
	logic [1:0]   ph_ff, nxt_ph;
	logic [7:0]   tx_ff, nxt_tx;
	logic [3:0]   tc_ff, nxt_tc;
	logic [7:0]   rx_ff, nxt_rx;
	logic         rv_ff, nxt_rv;
	logic         rc_ff, nxt_rc;
	logic         lr_ff, nxt_lr;
	logic         sr_ff, nxt_sr;
	logic         sp;
	logic         fall;

	// Phase: 0 awaiting address cmd, 1 awaiting function, 2 payload
	assign sp   = od_ff;
	assign fall = dq_ff & ~bus.dq;

	always_comb
	begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff + 16'h0001;
		nxt_dq  = bus.dq;
		nxt_od  = od_ff;
		nxt_oe  = 1'b0;
		nxt_bit = bit_ff;
		nxt_sh  = sh_ff;
		nxt_nb  = nb_ff;
		nxt_ph  = ph_ff;
		nxt_tx  = tx_ff;
		nxt_tc  = tc_ff;
		nxt_rx  = rx_ff;
		nxt_rv  = 1'b0;
		nxt_rc  = rc_ff;
		nxt_lr  = 1'b0;
		nxt_sr  = 1'b0;
		if (i_tx_load && tc_ff == 4'h0)
		begin
			nxt_tx = i_tx_data;
			nxt_tc = 4'h8;
		end
		unique case (st_ff)
			SWLD_IDLE:
				if (fall)
				begin
					nxt_st  = SWLD_SLOT;
					nxt_cnt = 16'h0001;
					nxt_bit = ~(tc_ff != 4'h0 && !tx_ff[0]);
					nxt_oe  = tc_ff != 4'h0 && !tx_ff[0];
				end
			SWLD_SLOT:
			begin
				nxt_oe = oe_ff;
				if (cnt_ff == SAMPLE_CYC[sp])
					nxt_bit = bus.dq;
				if (oe_ff && cnt_ff >= RDV_CYC[sp] + W1_LOW_CYC[sp])
					nxt_oe = 1'b0;
				if (cnt_ff >= RESET_DET_CYC[sp] && !bus.dq)
				begin
					nxt_st = SWLD_LOW;
					nxt_oe = 1'b0;
				end
				else if (bus.dq && !oe_ff && cnt_ff > SAMPLE_CYC[sp])
				begin
					nxt_st = SWLD_IDLE;
					if (tc_ff != 4'h0)
					begin
						nxt_tx = {1'b0, tx_ff[7:1]};
						nxt_tc = tc_ff - 4'h1;
					end
					else
					begin
						nxt_sh = {bit_ff, sh_ff[7:1]};
						nxt_nb = nb_ff + 3'h1;
						if (nb_ff == 3'h7)
						begin
							nxt_rx = {bit_ff, sh_ff[7:1]};
							nxt_rv = 1'b1;
							nxt_rc = ph_ff == 2'h1;
							if (ph_ff == 2'h0)
								nxt_ph = 2'h1;
							else if (ph_ff == 2'h1)
							begin
								nxt_ph = 2'h2;
								unique case ({bit_ff, sh_ff[7:1]})
									CMD_SET_OVERDRIVE: nxt_od = 1'b1;
									CMD_CLR_OVERDRIVE: nxt_od = 1'b0;
									CMD_SOFT_RESET:    nxt_sr = 1'b1;
									default:           nxt_od = od_ff;
								endcase
							end
						end
					end
				end
			end
			SWLD_LOW:
				if (bus.dq)
				begin
					nxt_st  = SWLD_PWAIT;
					nxt_cnt = 16'h0001;
					nxt_lr  = 1'b1;
					nxt_ph  = 2'h0;
					nxt_nb  = 3'h0;
					nxt_tc  = 4'h0;
				end
			SWLD_PWAIT:
				if (cnt_ff >= PRES_WAIT_CYC[sp])
				begin
					nxt_st  = SWLD_PLOW;
					nxt_cnt = 16'h0001;
					nxt_oe  = 1'b1;
				end
			SWLD_PLOW:
			begin
				nxt_oe = 1'b1;
				if (cnt_ff >= PRES_LOW_CYC[sp])
				begin
					nxt_oe = 1'b0;
					nxt_st = SWLD_WAITHI;
				end
			end
			SWLD_WAITHI:
				if (bus.dq)
					nxt_st = SWLD_IDLE;
			default:
				nxt_st = SWLD_IDLE;
		endcase
		if (st_ff == SWLD_IDLE && !fall && !bus.dq && !dq_ff)
		begin
			nxt_st  = SWLD_SLOT;
			nxt_cnt = 16'h0001;
		end
		if (sr_ff)
		begin
			nxt_od = SPEED_RESET;
			nxt_ph = 2'h0;
			nxt_tc = 4'h0;
			nxt_nb = 3'h0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			st_ff  <= SWLD_IDLE;
			cnt_ff <= '0;
			dq_ff  <= 1'b1;
			od_ff  <= SPEED_RESET;
			oe_ff  <= 1'b0;
			bit_ff <= 1'b1;
			sh_ff  <= 8'h00;
			nb_ff  <= 3'h0;
			ph_ff  <= 2'h0;
			tx_ff  <= 8'h00;
			tc_ff  <= 4'h0;
			rx_ff  <= 8'h00;
			rv_ff  <= 1'b0;
			rc_ff  <= 1'b0;
			lr_ff  <= 1'b0;
			sr_ff  <= 1'b0;
		end
		else
		begin
			st_ff  <= nxt_st;
			cnt_ff <= nxt_cnt;
			dq_ff  <= nxt_dq;
			od_ff  <= nxt_od;
			oe_ff  <= nxt_oe;
			bit_ff <= nxt_bit;
			sh_ff  <= nxt_sh;
			nb_ff  <= nxt_nb;
			ph_ff  <= nxt_ph;
			tx_ff  <= nxt_tx;
			tc_ff  <= nxt_tc;
			rx_ff  <= nxt_rx;
			rv_ff  <= nxt_rv;
			rc_ff  <= nxt_rc;
			lr_ff  <= nxt_lr;
			sr_ff  <= nxt_sr;
		end
	end

	// Enable only: the line is never driven high
	assign bus.device_oe = oe_ff;
	assign o_rx_data     = rx_ff;
	assign o_rx_valid    = rv_ff;
	assign o_rx_is_cmd   = rc_ff;
	assign o_tx_empty    = tc_ff == 4'h0;
	assign o_overdrive   = od_ff;
	assign o_line_reset  = lr_ff;
	assign o_soft_reset  = sr_ff;

endmodule : swl_device

// [core/swl_master.sv]
// Master end: reset pulse, write slots and read slots on the shared line
`timescale 1ns/100ps
module swl_master
	import swl_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	// Line
	swl_if.master           bus,
	// Requests
	input  wire logic       i_req,
	input  wire swl_pkg::swl_op_t i_op,
	input  wire logic       i_wbit,
	input  wire logic       i_overdrive,
	output logic            o_ready,
	// Answers
	output logic            o_done,
	output logic            o_rbit,
	output logic            o_presence
);
	import swl_pkg::*;

	typedef enum logic [2:0] {SWLM_IDLE, SWLM_RST, SWLM_RWAIT, SWLM_SLOT, SWLM_REC}
		swlm_state_t;

	////////////////////////////////////////////////////////////////////////
	swlm_state_t st_ff, nxt_st;
	swl_cnt_t    cnt_ff, nxt_cnt;
	swl_op_t     op_ff, nxt_op;
	logic        wb_ff, nxt_wb;
	logic        sp_ff, nxt_sp;
	logic        oe_ff, nxt_oe;
	logic        done_ff, nxt_done;
	logic        rb_ff, nxt_rb;
	logic        pr_ff, nxt_pr;
	swl_cnt_t    low_len;

	// Low time of a slot by kind
	always_comb
	begin
		if (op_ff == SWL_OP_READ)
			low_len = RD_INIT_CYC;
		else if (wb_ff)
			low_len = W1_LOW_CYC[sp_ff];
		else
			low_len = SLOT_CYC[sp_ff];
	end

	always_comb
	begin
		nxt_st   = st_ff;
		nxt_cnt  = cnt_ff + 16'h0001;
		nxt_op   = op_ff;
		nxt_wb   = wb_ff;
		nxt_sp   = sp_ff;
		nxt_oe   = oe_ff;
		nxt_done = 1'b0;
		nxt_rb   = rb_ff;
		nxt_pr   = pr_ff;
		unique case (st_ff)
			SWLM_IDLE:
				if (i_req)
				begin
					nxt_op  = i_op;
					nxt_wb  = i_wbit;
					nxt_sp  = i_overdrive;
					nxt_cnt = 16'h0001;
					nxt_oe  = 1'b1;
					nxt_st  = i_op == SWL_OP_RESET ? SWLM_RST : SWLM_SLOT;
				end
			SWLM_RST:
				if (cnt_ff >= RESET_LOW_CYC[sp_ff])
				begin
					nxt_oe  = 1'b0;
					nxt_cnt = 16'h0001;
					nxt_pr  = 1'b0;
					nxt_st  = SWLM_RWAIT;
				end
			SWLM_RWAIT:
			begin
				if (cnt_ff == PRES_SMP_CYC[sp_ff])
					nxt_pr = ~bus.dq;
				if (cnt_ff >= PRES_REST_CYC[sp_ff])
				begin
					nxt_done = 1'b1;
					nxt_st   = SWLM_IDLE;
				end
			end
			SWLM_SLOT:
			begin
				if (cnt_ff >= low_len)
					nxt_oe = 1'b0;
				if (op_ff == SWL_OP_READ && cnt_ff == RDV_CYC[sp_ff])
					nxt_rb = bus.dq;
				if (cnt_ff >= SLOT_CYC[sp_ff])
				begin
					nxt_oe  = 1'b0;
					nxt_cnt = 16'h0001;
					nxt_st  = SWLM_REC;
				end
			end
			SWLM_REC:
				if (cnt_ff >= REC_CYC && bus.dq)
				begin
					nxt_done = 1'b1;
					nxt_st   = SWLM_IDLE;
				end
			default:
				nxt_st = SWLM_IDLE;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			st_ff   <= SWLM_IDLE;
			cnt_ff  <= '0;
			op_ff   <= SWL_OP_RESET;
			wb_ff   <= 1'b1;
			sp_ff   <= SPEED_RESET;
			oe_ff   <= 1'b0;
			done_ff <= 1'b0;
			rb_ff   <= 1'b1;
			pr_ff   <= 1'b0;
		end
		else
		begin
			st_ff   <= nxt_st;
			cnt_ff  <= nxt_cnt;
			op_ff   <= nxt_op;
			wb_ff   <= nxt_wb;
			sp_ff   <= nxt_sp;
			oe_ff   <= nxt_oe;
			done_ff <= nxt_done;
			rb_ff   <= nxt_rb;
			pr_ff   <= nxt_pr;
		end
	end

	assign bus.master_oe = oe_ff;
	assign o_ready       = st_ff == SWLM_IDLE;
	assign o_done        = done_ff;
	assign o_rbit        = rb_ff;
	assign o_presence    = pr_ff;

endmodule : swl_master

// [verif/swl_assertions.sv]
// Wire checks on the shared line between master and device ends
`timescale 1ns/100ps
module swl_assertions
	import swl_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Line signals
	input wire logic dq,
	input wire logic master_oe,
	input wire logic device_oe
);
	import swl_pkg::*;

	localparam int PW_S = int'(PRES_WAIT_CYC[0]);
	swl_cnt_t hi_ff, mlo_ff, dlo_ff, pw_ff;
	swl_cnt_t nxt_hi, nxt_mlo, nxt_dlo, nxt_pw;
	logic     pend_ff, nxt_pend;

	// Saturating run length
	function automatic swl_cnt_t run(input swl_cnt_t c, input logic en);
		run = !en ? '0 : (&c ? c : c + 16'h0001);
	endfunction : run

	always_comb
	begin
		nxt_hi   = run(hi_ff, dq);
		nxt_mlo  = run(mlo_ff, master_oe);
		nxt_dlo  = run(dlo_ff, device_oe);
		// Next master slot cancels the wait, so long write zeros never count
		nxt_pend = !device_oe && !master_oe && (pend_ff || mlo_ff >= RESET_LOW_CYC[1]);
		nxt_pw   = run(pw_ff, nxt_pend);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			hi_ff   <= '1;
			mlo_ff  <= '0;
			dlo_ff  <= '0;
			pw_ff   <= '0;
			pend_ff <= 1'b0;
		end
		else
		begin
			hi_ff   <= nxt_hi;
			mlo_ff  <= nxt_mlo;
			dlo_ff  <= nxt_dlo;
			pw_ff   <= nxt_pw;
			pend_ff <= nxt_pend;
		end
	end

	////////////////////////////////////////
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence pres_rise;
		$rose(device_oe) && $past(dq);
	endsequence
	sequence read_rise;
		$rose(device_oe) && !$past(dq);
	endsequence

	rec_gap_a: assert property ($rose(master_oe) |-> hi_ff >= REC_CYC)
		else $error("Master pulled line before recovery gap");
	init_low_a: assert property ($fell(master_oe) |-> mlo_ff >= RD_INIT_CYC)
		else $error("Master low pulse too short");
	bit_low_a: assert property (
		$fell(master_oe) |-> mlo_ff <= RDV_CYC[0] || mlo_ff >= SLOT_CYC[1])
		else $error("Master low time inside sample window");
	rst_low_a: assert property (
		$fell(master_oe) && mlo_ff > SLOT_CYC[0] + 4 |-> mlo_ff >= RESET_LOW_CYC[0])
		else $error("Reset pulse too short");
	pres_at_a: assert property (
		pres_rise |-> hi_ff >= PRES_WAIT_CYC[1] && hi_ff <= PW_S + 8)
		else $error("Presence started at wrong time");
	pres_due_a: assert property (pw_ff <= PW_S + 12)
		else $error("No presence after reset pulse");
	dev_len_a: assert property (
		$fell(device_oe) |-> dlo_ff >= RDV_CYC[1] && dlo_ff <= PRES_LOW_CYC[0] + 4)
		else $error("Device low time out of range");
	rd_rise_a: assert property (read_rise |-> master_oe && mlo_ff <= 4)
		else $error("Device pulled line outside a slot start");
	rd_rel_a: assert property (read_rise |-> ##[1:1000] !device_oe)
		else $error("Device held read zero too long");
endmodule : swl_assertions

// [verif/tb.sv]
// Self-checking bench: master and device ends joined on one shared line
`timescale 1ns/100ps
module tb;
	import swl_pkg::*;
	logic        i_clk, i_rst_b, req, wbit, od, tx_load, eod;
	logic        ready, done, rbit, pres, rx_valid, rx_cmd, tx_empty, ovd, lrst, srst;
	logic [7:0]  tx_data, rx_data;
	logic [8:0]  got[$];
	swl_op_t     op;
	int          bad_count, check_count, cyc, ebyte, esr, nsr, elr, nlr;
	int unsigned seed;

	swl_if sw_bus();
	swl_master i_swl_master(.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(sw_bus.master), .i_req(req),
		.i_op(op), .i_wbit(wbit), .i_overdrive(od), .o_ready(ready), .o_done(done),
		.o_rbit(rbit), .o_presence(pres));
	swl_device i_swl_device(.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(sw_bus.device),
		.o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_rx_is_cmd(rx_cmd), .i_tx_data(tx_data),
		.i_tx_load(tx_load), .o_tx_empty(tx_empty), .o_overdrive(ovd), .o_line_reset(lrst),
		.o_soft_reset(srst));
	swl_assertions i_swl_assertions(.i_clk(i_clk), .i_rst_b(i_rst_b), .dq(sw_bus.dq),
		.master_oe(sw_bus.master_oe), .device_oe(sw_bus.device_oe));

	////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	task automatic chk_bit(input logic got_v, input logic exp_v);
		check_count++;
		if (got_v !== exp_v)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got_v, exp_v);
		end
	endtask : chk_bit

	task automatic chk_byte(input logic [8:0] got_v, input logic [8:0] exp_v);
		check_count++;
		if (got_v !== exp_v)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got_v, exp_v);
		end
	endtask : chk_byte

	task automatic complete_run();
		$display("Checks %0d, errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// One master operation; lo counts low cycles on the line
	task automatic run_op(input swl_op_t o, input logic b, output int lo);
		@(posedge i_clk);
		req  <= 1'b1;
		op   <= o;
		wbit <= b;
		od   <= eod;
		@(posedge i_clk);
		req <= 1'b0;
		lo = 0;
		do
		begin
			@(negedge i_clk);
			lo += !sw_bus.dq;
		end
		while (done !== 1'b1);
	endtask : run_op

	task automatic bus_reset();
		int lo;
		run_op(SWL_OP_RESET, 1'b0, lo);
		elr++;
		chk_bit(pres, 1'b1);
		chk_bit(lo >= RESET_LOW_CYC[eod] + PRES_LOW_CYC[eod], 1'b1);
		chk_byte(9'(nlr), 9'(elr));
		ebyte = 0;
	endtask : bus_reset

	task automatic wr_byte(input logic [7:0] v);
		int lo;
		got.delete();
		for (int i = 0; i < 8; i++)
		begin
			run_op(SWL_OP_WRITE, v[i], lo);
			chk_bit(lo < RDV_CYC[eod], v[i]);
		end
		chk_byte(got[$], {ebyte == 1, v});
		chk_byte(9'(got.size()), 9'h001);
		if (ebyte == 1)
		begin
			if (v == CMD_SET_OVERDRIVE)
				eod = 1'b1;
			if (v == CMD_CLR_OVERDRIVE || v == CMD_SOFT_RESET)
				eod = 1'b0;
			if (v == CMD_SOFT_RESET)
				esr++;
		end
		ebyte++;
		chk_bit(ovd, eod);
		chk_byte(9'(nsr), 9'(esr));
	endtask : wr_byte

	task automatic rd_byte();
		logic [7:0] v;
		int         lo;
		v = rnd();
		@(posedge i_clk);
		tx_data <= v;
		tx_load <= 1'b1;
		@(posedge i_clk);
		tx_load <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			run_op(SWL_OP_READ, 1'b1, lo);
			chk_bit(rbit, v[i]);
			chk_bit(lo < RDV_CYC[eod], v[i]);
		end
		chk_bit(tx_empty, 1'b1);
		ebyte++;
	endtask : rd_byte

	////////////////////////////////////////
	always @(negedge i_clk)
	begin
		if (rx_valid === 1'b1)
			got.push_back({rx_cmd, rx_data});
		nsr += (srst === 1'b1);
		nlr += (lrst === 1'b1);
	end

	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 350000)
		begin
			bad_count++;
			complete_run();
		end
	end

	initial
	begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	initial
	begin
		seed    = 82;
		i_rst_b = 1'b0;
		req     = 1'b0;
		op      = SWL_OP_RESET;
		wbit    = 1'b0;
		od      = 1'b0;
		tx_data = 8'h00;
		tx_load = 1'b0;
		eod     = 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(negedge i_clk);
		chk_bit(ovd, 1'b0);
		chk_bit(ready & rbit & sw_bus.dq, 1'b1);
		bus_reset();
		wr_byte(rnd());
		wr_byte(CMD_SET_OVERDRIVE);
		bus_reset();
		wr_byte(rnd());
		wr_byte(8'h0c);
		wr_byte(CMD_CLR_OVERDRIVE);
		wr_byte(rnd());
		rd_byte();
		rd_byte();
		bus_reset();
		wr_byte(rnd());
		wr_byte(CMD_CLR_OVERDRIVE);
		bus_reset();
		wr_byte(rnd());
		wr_byte(CMD_SOFT_RESET);
		complete_run();
	end
endmodule : tb
